// ---- swk_defines.svh ----
`ifndef SWK_DEFINES_SVH
`define SWK_DEFINES_SVH

// Master clock status codes
`define SWK_CODE_HSRC 3'h0
`define SWK_CODE_MAIN 3'h1
`define SWK_CODE_PLL 3'h2
`define SWK_CODE_LSRC 3'h4
`define SWK_CODE_SUB 3'h5

// Standby type code that requests a stop-class mode
`define SWK_STBTYPE_STOP 2'h2

// Oscillator wait mask bit positions
`define SWK_OSC_HSRC 0
`define SWK_OSC_MAIN 1
`define SWK_OSC_PLL 2
`define SWK_OSC_LSRC 3
`define SWK_OSC_SUB 4
`define SWK_OSC_NUM 5

// Synchronised input bit positions
`define SWK_IN_EXTRST 0
`define SWK_IN_LVDRST 1
`define SWK_IN_LVDIRQ 2
`define SWK_IN_NMI 3
`define SWK_IN_EXTIRQ 4
`define SWK_IN_USBWAKE 5
`define SWK_IN_RTCIRQ 6
`define SWK_IN_CECRX 7
`define SWK_IN_REMOTERX 8
`define SWK_IN_WAKEPIN 9
`define SWK_IN_RDY 10
`define SWK_IN_NUM 15

// Timing
`define SWK_MCLK_MHZ 250
`define SWK_REG_SETTLE_NS 300000
`define SWK_REG_SETTLE_CYC (((`SWK_REG_SETTLE_NS * `SWK_MCLK_MHZ) + 999) / 1000)

`endif

// ---- swk_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module swk_osc_model #(
    parameter int DLY = 5
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       reset,
    // Oscillator enables and ready flags
    input wire logic [4:0] runEn,
    output logic [4:0]     ready
);
    int cnt [5];
    // startup delay before ready; drops at once when stopped
    always @(posedge mclk or posedge reset) begin
        for (int i = 0; i < 5; i++) begin
            if (reset || !runEn[i]) begin
                cnt[i] <= 0;
                ready[i] <= 1'b0;
            end else if (cnt[i] < DLY) begin
                cnt[i] <= cnt[i] + 1;
            end else begin
                ready[i] <= 1'b1;
            end
        end
    end
endmodule : swk_osc_model
`default_nettype wire

// ---- swk_pkg.sv ----
package swk_pkg;

    typedef enum logic [2:0] {
        ST_RUN  = 3'h0,
        ST_STOP = 3'h1,
        ST_DSTB = 3'h4,
        ST_REGW = 3'h3,
        ST_OSCW = 3'h2
    } swk_state_type;

    typedef enum logic [1:0] {
        LP_NONE   = 2'h0,
        LP_STOP   = 2'h1,
        LP_DSRTC  = 2'h2,
        LP_DSSTOP = 2'h3
    } swk_lp_type;

    typedef struct packed {
        swk_state_type state;
        swk_lp_type    lp;
        logic [2:0]    clkCodeLatched;
        logic [4:0]    waitMask;
        logic          byReset;
        logic          prioLow;
        logic          rtcEn;
        logic [2:0]    runMode;
        logic [4:0]    oscEn;
        logic          usbPllEn;
        logic          cpuClkEn;
        logic          busClkEn;
        logic          intCtrlRst;
        logic          irqHold;
    } swk_main_type;

endpackage : swk_pkg

// ---- swk_stop_wakeup.sv ----
`include "swk_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module swk_stop_wakeup #(
    parameter int REG_SETTLE_CYCLES = `SWK_REG_SETTLE_CYC
) (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset,
    // Entry request from the core
    input wire logic        deepSleepReq,
    input wire logic        deepStandbySelectBit,
    input wire logic [1:0]  standbyTypeField,
    // RTC-mode enable write
    input wire logic        rtcModeEnableWr,
    input wire logic        rtcModeEnableWrData,
    // Clock configuration
    input wire logic [2:0]  masterClockStatusField,
    input wire logic        mainOscEnableBit,
    input wire logic        pllInputSourceBit,
    input wire logic        pllEnableBit,
    input wire logic        subOscEnableBit,
    input wire logic        irqPriorityOk,
    // Wake sources, asynchronous
    input wire logic        externalResetPin_n,
    input wire logic        lvdReset,
    input wire logic        lvdIrq,
    input wire logic        nmiIrq,
    input wire logic        extIrq,
    input wire logic        usbWakeIrq,
    input wire logic        rtcIrq,
    input wire logic        cecRxIrq,
    input wire logic        remoteRxIrq,
    input wire logic        wakeupPin,
    // Oscillator ready, asynchronous
    input wire logic [4:0]  oscReady,
    // Clock controls
    output logic [4:0]      oscRunEn,
    output logic            usbPllRunEn,
    output logic            cpuClkEn,
    output logic            ahbClkEn,
    output logic [2:0]      apbClkEn,
    // Status
    output swk_pkg::swk_state_type seqState,
    output swk_pkg::swk_lp_type    lowPowerMode,
    output logic [2:0]      runMode,
    output logic            rtcModeEnableBit,
    output logic            subOscReadyBit,
    output logic            regTransitionWait,
    output logic            intCtrlResetPulse,
    output logic            irqFlagsHold
);
    import swk_pkg::*;

    initial begin
        if (REG_SETTLE_CYCLES < 1) begin
            $error("swk_stop_wakeup: REG_SETTLE_CYCLES must be at least 1");
        end
    end

    logic [`SWK_IN_NUM-1:0] pinBus;
    logic [`SWK_IN_NUM-1:0] syn;
    logic [4:0]             rdy;
    logic                   rstWake;
    logic                   stopIrqWake;
    logic                   dsWake;
    logic                   stopReq;

    swk_main_type s_q;
    swk_main_type s_d;

    swk_wait_if regWait ();

    assign pinBus = {oscReady, wakeupPin, remoteRxIrq, cecRxIrq, rtcIrq, usbWakeIrq,
                     extIrq, nmiIrq, lvdIrq, lvdReset, ~externalResetPin_n};

    swk_sync #(
        .W (`SWK_IN_NUM)
    ) u_sync (
        .mclk    (mclk),
        .reset   (reset),
        .pinIn   (pinBus),
        .syncOut (syn)
    );

    swk_wait_timer #(
        .CYCLES (REG_SETTLE_CYCLES)
    ) u_regwait (
        .mclk  (mclk),
        .reset (reset),
        .wt    (regWait.timer)
    );

    assign rdy = syn[`SWK_IN_RDY +: 5];

    // Oscillator wait mask for an interrupt wake
    function automatic logic [4:0] irqWaitMask(
        input logic [2:0] clkCode,
        input logic       mainEn,
        input logic       pllSrc,
        input logic       pllEn,
        input logic       subEn
    );
        logic [4:0] m;
        m = '0;
        // low-speed RC always, high-speed RC by code
        m[`SWK_OSC_LSRC] = 1'b1;
        m[`SWK_OSC_HSRC] = (clkCode == `SWK_CODE_HSRC) || (clkCode == `SWK_CODE_MAIN)
                           || (clkCode == `SWK_CODE_PLL);
        m[`SWK_OSC_MAIN] = ((clkCode == `SWK_CODE_HSRC) && mainEn)
                           || (clkCode == `SWK_CODE_MAIN)
                           || ((clkCode == `SWK_CODE_PLL) && !pllSrc);
        m[`SWK_OSC_PLL]  = ((clkCode == `SWK_CODE_MAIN) && pllEn) || (clkCode == `SWK_CODE_PLL);
        m[`SWK_OSC_SUB]  = subEn || (clkCode == `SWK_CODE_SUB);
        return m;
    endfunction : irqWaitMask

    // only pin and low-voltage resets are wired in
    assign rstWake = syn[`SWK_IN_EXTRST] || syn[`SWK_IN_LVDRST];
    assign stopIrqWake = syn[`SWK_IN_NMI] || syn[`SWK_IN_EXTIRQ]
                         || syn[`SWK_IN_USBWAKE] || syn[`SWK_IN_LVDIRQ];
    // deep standby sources; RTC and receive interrupts only in the RTC variant
    assign dsWake = rstWake || syn[`SWK_IN_LVDIRQ] || syn[`SWK_IN_WAKEPIN]
                    || ((s_q.lp == LP_DSRTC) && (syn[`SWK_IN_RTCIRQ]
                    || syn[`SWK_IN_CECRX] || syn[`SWK_IN_REMOTERX]));
    assign stopReq = deepSleepReq && (standbyTypeField == `SWK_STBTYPE_STOP);

    always_comb begin
        s_d = s_q;
        s_d.intCtrlRst = 1'b0;
        regWait.start = 1'b0;
        case (s_q.state)
            ST_RUN: begin
                if (s_q.prioLow && irqPriorityOk) begin
                    s_d.prioLow = 1'b0;
                end
                // enable set needs sub oscillator ready
                if (rtcModeEnableWr) begin
                    if (!rtcModeEnableWrData) begin
                        s_d.rtcEn = 1'b0;
                    end else if (syn[`SWK_IN_RDY + `SWK_OSC_SUB]) begin
                        s_d.rtcEn = 1'b1;
                    end
                end
                if (stopReq && deepStandbySelectBit) begin
                    s_d.state = ST_DSTB;
                    s_d.lp = s_q.rtcEn ? LP_DSRTC : LP_DSSTOP;
                    s_d.irqHold = 1'b0;
                end else if (stopReq && !s_q.rtcEn) begin
                    s_d.state = ST_STOP;
                    s_d.lp = LP_STOP;
                    s_d.clkCodeLatched = masterClockStatusField;
                end
            end
            ST_STOP: begin
                // no debugger path out of stop
                if (rstWake) begin
                    // reset wake waits both RC oscillators
                    s_d.state = ST_REGW;
                    s_d.byReset = 1'b1;
                    s_d.waitMask = 5'h0;
                    s_d.waitMask[`SWK_OSC_HSRC] = 1'b1;
                    s_d.waitMask[`SWK_OSC_LSRC] = 1'b1;
                    regWait.start = 1'b1;
                end else if (stopIrqWake) begin
                    s_d.state = ST_REGW;
                    s_d.byReset = 1'b0;
                    s_d.prioLow = !irqPriorityOk;
                    s_d.waitMask = irqWaitMask(s_q.clkCodeLatched, mainOscEnableBit,
                                               pllInputSourceBit, pllEnableBit,
                                               subOscEnableBit);
                    regWait.start = 1'b1;
                end
            end
            ST_DSTB: begin
                if (dsWake) begin
                    s_d.state = ST_REGW;
                    s_d.byReset = 1'b1;
                    s_d.waitMask = 5'h0;
                    s_d.waitMask[`SWK_OSC_HSRC] = 1'b1;
                    s_d.waitMask[`SWK_OSC_LSRC] = 1'b1;
                    regWait.start = 1'b1;
                end
            end
            ST_REGW: begin
                if (regWait.done) begin
                    s_d.state = ST_OSCW;
                end
            end
            ST_OSCW: begin
                if ((s_q.waitMask & ~rdy) == 5'h0) begin
                    s_d.state = ST_RUN;
                    s_d.runMode = s_q.byReset ? `SWK_CODE_HSRC : s_q.clkCodeLatched;
                    if (s_q.lp == LP_DSRTC || s_q.lp == LP_DSSTOP) begin
                        s_d.intCtrlRst = 1'b1;
                        s_d.irqHold = 1'b1;
                    end
                    s_d.lp = LP_NONE;
                end
            end
            default: begin
                s_d.state = ST_RUN;
                s_d.lp = LP_NONE;
            end
        endcase
        // Clock enables from the next state
        case (s_d.state)
            ST_RUN: begin
                s_d.oscEn = 5'h0;
                s_d.oscEn[`SWK_OSC_HSRC] = 1'b1;
                s_d.oscEn[`SWK_OSC_LSRC] = 1'b1;
                s_d.oscEn[`SWK_OSC_MAIN] = mainOscEnableBit
                                           || (s_d.runMode == `SWK_CODE_MAIN);
                s_d.oscEn[`SWK_OSC_PLL] = pllEnableBit || (s_d.runMode == `SWK_CODE_PLL);
                s_d.oscEn[`SWK_OSC_SUB] = subOscEnableBit || s_d.rtcEn
                                          || (s_d.runMode == `SWK_CODE_SUB);
                s_d.usbPllEn = 1'b1;
                s_d.busClkEn = 1'b1;
                s_d.cpuClkEn = !s_d.prioLow;
            end
            ST_DSTB: begin
                // only the sub clock survives, in the RTC variant
                s_d.oscEn = 5'h0;
                s_d.oscEn[`SWK_OSC_SUB] = (s_d.lp == LP_DSRTC);
                s_d.usbPllEn = 1'b0;
                s_d.busClkEn = 1'b0;
                s_d.cpuClkEn = 1'b0;
            end
            ST_REGW, ST_OSCW: begin
                s_d.oscEn = s_d.waitMask;
                s_d.usbPllEn = 1'b0;
                s_d.busClkEn = 1'b0;
                s_d.cpuClkEn = 1'b0;
            end
            default: begin
                s_d.oscEn = 5'h0;
                s_d.usbPllEn = 1'b0;
                s_d.busClkEn = 1'b0;
                s_d.cpuClkEn = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '{state: ST_RUN, lp: LP_NONE, clkCodeLatched: `SWK_CODE_HSRC,
                     waitMask: 5'h0, byReset: 1'b0, prioLow: 1'b0, rtcEn: 1'b0,
                     runMode: `SWK_CODE_HSRC, oscEn: 5'h09, usbPllEn: 1'b1,
                     cpuClkEn: 1'b1, busClkEn: 1'b1, intCtrlRst: 1'b0, irqHold: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign oscRunEn          = s_q.oscEn;
    assign usbPllRunEn       = s_q.usbPllEn;
    assign cpuClkEn          = s_q.cpuClkEn;
    assign ahbClkEn          = s_q.busClkEn;
    assign apbClkEn          = {3{s_q.busClkEn}};
    assign seqState          = s_q.state;
    assign lowPowerMode      = s_q.lp;
    assign runMode           = s_q.runMode;
    assign rtcModeEnableBit  = s_q.rtcEn;
    assign subOscReadyBit    = syn[`SWK_IN_RDY + `SWK_OSC_SUB];
    assign regTransitionWait = (s_q.state == ST_REGW);
    assign intCtrlResetPulse = s_q.intCtrlRst;
    assign irqFlagsHold      = s_q.irqHold;

    // reset wake ends in high-speed RC
    property p_reset_hsrc;
        @(posedge mclk) disable iff (reset)
        (s_q.state == ST_OSCW && s_q.byReset && s_d.state == ST_RUN)
        |=> (runMode == `SWK_CODE_HSRC);
    endproperty
    a_reset_hsrc: assert property (p_reset_hsrc) else $error("reset wake mode wrong");

    property p_stop_irq;
        @(posedge mclk) disable iff (reset)
        (s_q.state == ST_STOP && !rstWake && stopIrqWake) |=> (s_q.state == ST_REGW);
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("stop irq did not wake");

    property p_irq_mode;
        @(posedge mclk) disable iff (reset)
        (s_q.state == ST_OSCW && !s_q.byReset && s_d.state == ST_RUN)
        |=> (runMode == $past(s_q.clkCodeLatched));
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq run mode wrong");

    property p_reset_mask;
        @(posedge mclk) disable iff (reset)
        (s_q.state == ST_REGW && s_q.byReset) |-> (s_q.waitMask == 5'h09);
    endproperty
    a_reset_mask: assert property (p_reset_mask) else $error("reset wait mask");

    property p_lsrc_wait;
        @(posedge mclk) disable iff (reset)
        (s_q.state == ST_OSCW && !rdy[`SWK_OSC_LSRC]) |=> (s_q.state == ST_OSCW);
    endproperty
    a_lsrc_wait: assert property (p_lsrc_wait) else $error("left without LS RC");

    property p_sub_code;
        @(posedge mclk) disable iff (reset)
        (s_q.state == ST_REGW && !s_q.byReset && s_q.clkCodeLatched == `SWK_CODE_SUB)
        |-> (s_q.waitMask[`SWK_OSC_SUB] && !s_q.waitMask[`SWK_OSC_HSRC]);
    endproperty
    a_sub_code: assert property (p_sub_code) else $error("sub code mask wrong");

    property p_reg_first;
        @(posedge mclk) disable iff (reset)
        $rose(s_q.state == ST_REGW) |-> (s_q.state == ST_REGW) [*8];
    endproperty
    a_reg_first: assert property (p_reg_first) else $error("settle wait too short");

    property p_prio;
        @(posedge mclk) disable iff (reset)
        (s_q.state == ST_RUN && s_q.prioLow && !irqPriorityOk) |=> !cpuClkEn && ahbClkEn;
    endproperty
    a_prio: assert property (p_prio) else $error("cpu ran at low priority");

    property p_rtc_en;
        @(posedge mclk) disable iff (reset)
        (!s_q.rtcEn && !subOscReadyBit) |=> !rtcModeEnableBit;
    endproperty
    a_rtc_en: assert property (p_rtc_en) else $error("rtc enable set without ready");

    property p_ds_clk;
        @(posedge mclk) disable iff (reset)
        (seqState == ST_DSTB) |-> !cpuClkEn && !usbPllRunEn && (apbClkEn == 3'h0)
        && (oscRunEn[`SWK_OSC_SUB] == (lowPowerMode == LP_DSRTC));
    endproperty
    a_ds_clk: assert property (p_ds_clk) else $error("deep standby clocks wrong");

    property p_ds_stop_src;
        @(posedge mclk) disable iff (reset)
        (s_q.state == ST_DSTB && s_q.lp == LP_DSSTOP && !rstWake
         && !syn[`SWK_IN_LVDIRQ] && !syn[`SWK_IN_WAKEPIN]) |=> (s_q.state == ST_DSTB);
    endproperty
    a_ds_stop_src: assert property (p_ds_stop_src) else $error("bad deep stop wake");

    property p_ds_reset;
        @(posedge mclk) disable iff (reset)
        $rose(intCtrlResetPulse) |-> irqFlagsHold ##1 !intCtrlResetPulse;
    endproperty
    a_ds_reset: assert property (p_ds_reset) else $error("transition reset pulse");

    property p_code_hold;
        @(posedge mclk) disable iff (reset)
        (s_q.state != ST_RUN) |=> $stable(s_q.clkCodeLatched);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("clock code changed");

    property p_cpu_last;
        @(posedge mclk) disable iff (reset)
        (s_q.state == ST_REGW || s_q.state == ST_OSCW) |-> !cpuClkEn;
    endproperty
    a_cpu_last: assert property (p_cpu_last) else $error("cpu clock early");

    c_stop_irq: cover property (@(posedge mclk) disable iff (reset)
        s_q.state == ST_STOP ##1 s_q.state == ST_REGW && !s_q.byReset);
    c_stop_rst: cover property (@(posedge mclk) disable iff (reset)
        s_q.state == ST_STOP ##1 s_q.state == ST_REGW && s_q.byReset);
    c_ds_exit: cover property (@(posedge mclk) disable iff (reset) $rose(intCtrlResetPulse));
    c_prio_low: cover property (@(posedge mclk) disable iff (reset)
        s_q.state == ST_RUN && s_q.prioLow);
endmodule : swk_stop_wakeup
`default_nettype wire

// ---- swk_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module swk_sync #(
    parameter int W = 15
) (
    // Clock and reset
    input wire logic         mclk,
    input wire logic         reset,
    // Pins
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0]     syncOut
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } swk_sync_type;

    swk_sync_type s_q;
    swk_sync_type s_d;

    initial begin
        if (W < 1) begin
            $error("swk_sync: W must be at least 1");
        end
    end

    // First stage feeds only the second stage
    always_comb begin
        s_d.meta = pinIn;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign syncOut = s_q.sync;
endmodule : swk_sync
`default_nettype wire

// ---- swk_wait_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface swk_wait_if;
    logic start;
    logic done;
    modport ctrl  (output start, input done);
    modport timer (input start, output done);
endinterface : swk_wait_if
`default_nettype wire

// ---- swk_wait_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module swk_wait_timer #(
    parameter int CYCLES = 75000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Wait handshake
    swk_wait_if.timer wt
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          busy;
        logic          done;
    } swk_tmr_type;

    swk_tmr_type s_q;
    swk_tmr_type s_d;

    initial begin
        if (CYCLES < 1) begin
            $error("swk_wait_timer: CYCLES must be at least 1");
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (wt.start) begin
            s_d.cnt  = CW'(CYCLES - 1);
            s_d.busy = 1'b1;
        end else if (s_q.busy) begin
            if (s_q.cnt == '0) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - CW'(1);
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign wt.done = s_q.done;
endmodule : swk_wait_timer
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import swk_pkg::*;
    localparam int REGN = 20;
    logic mclk, reset, deepSleepReq, deepStandbySelectBit, rtcModeEnableWr, rtcModeEnableWrData;
    logic mainOscEnableBit, pllInputSourceBit, pllEnableBit, subOscEnableBit, irqPriorityOk;
    logic [1:0] standbyTypeField;
    logic [2:0] masterClockStatusField, runMode, apbClkEn;
    logic [4:0] oscReady, oscRunEn;
    logic [9:0] src;
    logic usbPllRunEn, cpuClkEn, ahbClkEn, rtcModeEnableBit, subOscReadyBit;
    logic regTransitionWait, intCtrlResetPulse, irqFlagsHold;
    swk_state_type seqState;
    swk_lp_type lowPowerMode;
    int err_count = 0;
    int total_checks = 0;
    int pulses = 0;

    swk_stop_wakeup #(.REG_SETTLE_CYCLES(REGN)) uut (
        .mclk, .reset, .deepSleepReq, .deepStandbySelectBit, .standbyTypeField,
        .rtcModeEnableWr, .rtcModeEnableWrData, .masterClockStatusField,
        .mainOscEnableBit, .pllInputSourceBit, .pllEnableBit, .subOscEnableBit,
        .irqPriorityOk, .externalResetPin_n(~src[0]), .lvdReset(src[1]), .lvdIrq(src[2]),
        .nmiIrq(src[3]), .extIrq(src[4]), .usbWakeIrq(src[5]), .rtcIrq(src[6]),
        .cecRxIrq(src[7]), .remoteRxIrq(src[8]), .wakeupPin(src[9]), .oscReady,
        .oscRunEn, .usbPllRunEn, .cpuClkEn, .ahbClkEn, .apbClkEn, .seqState,
        .lowPowerMode, .runMode, .rtcModeEnableBit, .subOscReadyBit,
        .regTransitionWait, .intCtrlResetPulse, .irqFlagsHold
    );
    swk_osc_model osc (.mclk, .reset, .runEn(oscRunEn), .ready(oscReady));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Counted mid-cycle so a check at the following rising edge sees it
    always @(negedge mclk) if (intCtrlResetPulse === 1'b1) pulses++;

    task give_verdict;
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task chk(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t check failed", $time);
        end
    endtask : chk

    task enter(input logic ds);
        @(posedge mclk) begin
            deepSleepReq <= 1'b1;
            deepStandbySelectBit <= ds;
        end
        @(posedge mclk) deepSleepReq <= 1'b0;
        @(negedge mclk);
    endtask : enter

    // Source held as a level until the run mode is back
    task wake(input int b, input logic [4:0] m, input logic [2:0] r);
        int n;
        @(posedge mclk) src[b] <= 1'b1;
        n = 0;
        while (seqState !== ST_REGW && n < 20) begin
            @(negedge mclk);
            n++;
        end
        chk(oscRunEn === m);
        n = 0;
        while (regTransitionWait === 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk(n == REGN + 1);
        n = 0;
        while (seqState !== ST_RUN && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk(runMode === r && ahbClkEn === 1'b1 && cpuClkEn === irqPriorityOk);
        @(posedge mclk) src[b] <= 1'b0;
    endtask : wake

    task nowake(input int b);
        @(posedge mclk) src[b] <= 1'b1;
        repeat (8) @(negedge mclk);
        chk(seqState === ST_DSTB);
        @(posedge mclk) src[b] <= 1'b0;
    endtask : nowake

    task run(input logic [2:0] c, input int b, input logic [4:0] m, input logic [2:0] r);
        @(posedge mclk) masterClockStatusField <= c;
        enter(1'b0);
        chk(seqState === ST_STOP && lowPowerMode === LP_STOP && cpuClkEn === 1'b0);
        wake(b, m, r);
    endtask : run

    task wr_rtc(input logic d);
        @(posedge mclk) begin
            rtcModeEnableWr <= 1'b1;
            rtcModeEnableWrData <= d;
        end
        @(posedge mclk) rtcModeEnableWr <= 1'b0;
        @(negedge mclk);
    endtask : wr_rtc

    initial begin
        reset = 1'b1;
        {deepSleepReq, deepStandbySelectBit, rtcModeEnableWr, rtcModeEnableWrData} = 4'h0;
        {pllEnableBit, subOscEnableBit} = 2'h0;
        {mainOscEnableBit, pllInputSourceBit, irqPriorityOk} = 3'h7;
        standbyTypeField = 2'h2;
        masterClockStatusField = 3'h0;
        src = 10'h000;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(negedge mclk);
        chk(oscRunEn === 5'h09 && cpuClkEn === 1'b1 && seqState === ST_RUN);
        run(3'h0, 3, 5'h0B, 3'h0);
        run(3'h1, 4, 5'h0B, 3'h1);
        run(3'h2, 5, 5'h0D, 3'h2);
        run(3'h4, 2, 5'h08, 3'h4);
        run(3'h5, 3, 5'h18, 3'h5);
        run(3'h5, 1, 5'h09, 3'h0);
        run(3'h2, 0, 5'h09, 3'h0);
        // Main off, PLL source main, PLL on, sub on
        @(posedge mclk) {mainOscEnableBit, pllInputSourceBit, pllEnableBit, subOscEnableBit} <= 4'h3;
        run(3'h0, 3, 5'h19, 3'h0);
        run(3'h1, 4, 5'h1F, 3'h1);
        run(3'h2, 5, 5'h1F, 3'h2);
        @(posedge mclk) {mainOscEnableBit, pllInputSourceBit, pllEnableBit, subOscEnableBit} <= 4'hC;
        @(posedge mclk) irqPriorityOk <= 1'b0;
        run(3'h1, 4, 5'h0B, 3'h1);
        @(posedge mclk) irqPriorityOk <= 1'b1;
        repeat (4) @(negedge mclk);
        chk(cpuClkEn === 1'b1);
        wr_rtc(1'b1);
        chk(rtcModeEnableBit === 1'b0 && subOscReadyBit === 1'b0);
        @(posedge mclk) subOscEnableBit <= 1'b1;
        repeat (12) @(negedge mclk);
        wr_rtc(1'b1);
        chk(rtcModeEnableBit === 1'b1 && subOscReadyBit === 1'b1);
        enter(1'b0);
        chk(seqState === ST_RUN);
        enter(1'b1);
        chk(lowPowerMode === LP_DSRTC && oscRunEn === 5'h10 && usbPllRunEn === 1'b0);
        nowake(3);
        wake(7, 5'h09, 3'h0);
        chk(pulses == 1 && irqFlagsHold === 1'b1);
        wr_rtc(1'b0);
        enter(1'b1);
        chk(lowPowerMode === LP_DSSTOP && oscRunEn === 5'h00 && apbClkEn === 3'h0);
        chk(irqFlagsHold === 1'b0);
        nowake(6);
        nowake(7);
        wake(9, 5'h09, 3'h0);
        chk(pulses == 2);
        give_verdict();
    end

    // Whole sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
